// ### rtl/thermal_sensor_config_reg.sv
// Purpose: Two-wire slave holding the sensor control register and pacing conversions.
// Assumes: The master drives SCL; SDA is open drain, low while sda_pin_oe is high.
// Notes: Temperature and limit registers beyond the current reading are outside.
// Overview of operation
// - Control register is 16 bits; only upper byte used, lower byte reads zero.
// - Reset loads the control register with all zeros.
// - Write is address with write bit, pointer 01h, then one data byte.
// - Only the first data byte after the pointer is stored; later bytes dropped.
// - Stop or restart before a full data byte leaves the register unchanged.
// - Trigger bit set in shutdown runs one conversion, then clears and sleeps.
// - Trigger bit written outside shutdown is ignored.
// - Trigger bit always reads back as zero.
// - Conversion takes 25 ms at 9 bits, doubling per added bit.
// - Bits 12:11 pick 1, 2, 4 or 6 consecutive faults before alarm.
// - Bit 10 zero makes the alarm active low, one active high.
// - Bit 9 picks comparator mode at zero, interrupt mode at one.
// - With bit 8 zero conversions run back to back continuously.
// - Setting shutdown lets the running conversion finish and store first.
// - Clearing shutdown resumes continuous conversions.
// - Reset sets the register pointer to 00h, the temperature register.
// - Reads send upper byte first; master ACK asks for lower, NACK ends.
`default_nettype none
module thermal_sensor_config_reg #(
    parameter int CONV_BASE_TICKS = thermal_cfg_pkg::CONV_9BIT_TICKS
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic scl_pin,
    input wire logic sda_pin_in,
    output logic sda_pin_out,
    output logic sda_pin_oe,
    input wire logic [2:0] addr_strap_pins,
    input wire logic [15:0] temp_sample,
    output logic [1:0] resolution_select,
    output logic [1:0] fault_queue_depth,
    output logic alarm_polarity,
    output logic alarm_mode_select,
    output logic shutdown_ctrl,
    output logic conv_busy,
    output logic temp_update,
    output logic [15:0] temp_value
);
    import thermal_cfg_pkg::*;

    conv_if cv ();

    conv_timer #(.BASE_TICKS(CONV_BASE_TICKS), .CNT_W(CONV_CNT_W)) u_timer (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .cv(cv)
    );

    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic scl_d_r;
    logic sda_d_r;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    i2c_state_e state_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] shreg_r;
    logic [7:0] rx_byte;
    logic [1:0] byte_idx_r;
    logic rw_r;
    logic ack_r;
    logic full_r;
    logic sda_oe_r;
    logic sda_out_r;
    logic [7:0] ptr_r;
    logic [7:0] cfg_r;
    logic cfg_wr_r;
    logic [7:0] wr_byte_r;
    logic [15:0] tx_word_r;
    logic lower_r;
    logic [7:0] cur_byte;
    logic [15:0] nxt_word, fresh_word;
    logic nxt_first;
    logic os_pend_r;
    logic os_run_r;
    logic [15:0] temp_r;
    logic temp_upd_r;

    function automatic logic [15:0] read_word(input logic [7:0] ptr, input logic [7:0] cfg,
                                              input logic [15:0] temp);
        if (ptr == PTR_TEMP)
            read_word = temp;
        else if (ptr == PTR_CFG)
            read_word = {1'b0, cfg[OS_BIT-1:0], CFG_LOW_BYTE};
        else
            read_word = UNMAPPED_WORD;
    endfunction

    // Pins cross in from the bus; only the second stage and its one-cycle delayed copy are ever looked at.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= 5'h1F;
            sync2_r <= 5'h1F;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            sync1_r <= {scl_pin, sda_pin_in, addr_strap_pins};
            sync2_r <= sync1_r;
            scl_d_r <= sync2_r[4];
            sda_d_r <= sync2_r[3];
        end
    end

    assign scl_s = sync2_r[4];
    assign sda_s = sync2_r[3];
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;
    assign rx_byte = {shreg_r[6:0], sda_s};
    assign cur_byte = lower_r ? tx_word_r[7:0] : tx_word_r[15:8];
    assign fresh_word = read_word(ptr_r, cfg_r, temp_r);
    assign nxt_word = lower_r ? fresh_word : tx_word_r;
    assign nxt_first = lower_r ? nxt_word[15] : nxt_word[7];

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 3'h0;
            shreg_r <= 8'h00;
            byte_idx_r <= IDX_ADDR;
            rw_r <= 1'b0;
            ack_r <= 1'b0;
            full_r <= 1'b0;
            sda_oe_r <= 1'b0;
            ptr_r <= PTR_RESET;
            cfg_wr_r <= 1'b0;
            wr_byte_r <= 8'h00;
            tx_word_r <= 16'h0000;
            lower_r <= 1'b0;
        end else begin
            cfg_wr_r <= 1'b0;
            if (start_det) begin
                // A partial byte simply dies in the shifter.
                state_r <= ST_RX;
                bit_cnt_r <= 3'h0;
                byte_idx_r <= IDX_ADDR;
                full_r <= 1'b0;
                sda_oe_r <= 1'b0;
            end else if (stop_det) begin
                state_r <= ST_IDLE;
                sda_oe_r <= 1'b0;
            end else begin
                unique case (state_r)
                    ST_IDLE: begin
                    end
                    ST_RX: begin
                        if (scl_rise) begin
                            shreg_r <= rx_byte;
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            if (bit_cnt_r == LAST_BIT) begin
                                full_r <= 1'b1;
                                if (byte_idx_r == IDX_ADDR) begin
                                    ack_r <= rx_byte[7:1] == {ADDR_PREFIX, sync2_r[2:0]};
                                    rw_r <= rx_byte[0];
                                end else if (byte_idx_r == IDX_PTR) begin
                                    ptr_r <= rx_byte;
                                    ack_r <= 1'b1;
                                end else begin
                                    ack_r <= 1'b1;
                                    if (byte_idx_r == IDX_DATA && ptr_r == PTR_CFG) begin
                                        cfg_wr_r <= 1'b1;
                                        wr_byte_r <= rx_byte;
                                    end
                                end
                            end
                        end else if (scl_fall && full_r) begin
                            full_r <= 1'b0;
                            state_r <= ack_r ? ST_ACK : ST_IDLE;
                            sda_oe_r <= ack_r;
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_r <= 3'h0;
                            if (byte_idx_r != IDX_MAX)
                                byte_idx_r <= byte_idx_r + 2'h1;
                            if (rw_r) begin
                                state_r <= ST_TX;
                                tx_word_r <= fresh_word;
                                lower_r <= 1'b0;
                                sda_oe_r <= !fresh_word[15];
                            end else begin
                                state_r <= ST_RX;
                                sda_oe_r <= 1'b0;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_rise) begin
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_r == 3'h0) begin
                                state_r <= ST_MACK;
                                sda_oe_r <= 1'b0;
                            end else begin
                                sda_oe_r <= !cur_byte[LAST_BIT - bit_cnt_r];
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            if (sda_s)
                                state_r <= ST_IDLE;
                            else
                                full_r <= 1'b1;
                        end else if (scl_fall && full_r) begin
                            // An ACK after the lower byte restarts with fresh data.
                            full_r <= 1'b0;
                            state_r <= ST_TX;
                            bit_cnt_r <= 3'h0;
                            tx_word_r <= nxt_word;
                            lower_r <= !lower_r;
                            sda_oe_r <= !nxt_first;
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // The trigger bit is never stored, so it always reads back as zero.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_r <= CFG_RESET;
        end else if (cfg_wr_r) begin
            cfg_r <= {1'b0, wr_byte_r[OS_BIT-1:0]};
        end
    end

    // Starts are held off while done is high so a finished run is not restarted twice.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cv.start <= 1'b0;
            cv.res <= 2'h0;
            os_pend_r <= 1'b0;
            os_run_r <= 1'b0;
            temp_r <= TEMP_RESET;
            temp_upd_r <= 1'b0;
        end else begin
            cv.start <= 1'b0;
            temp_upd_r <= 1'b0;
            if (!cv.start && !cv.busy && !cv.done && (!cfg_r[SD_BIT] || os_pend_r)) begin
                cv.start <= 1'b1;
                cv.res <= cfg_r[RES_LSB +: 2];
                os_run_r <= cfg_r[SD_BIT];
            end
            if (cv.done) begin
                temp_r <= temp_sample;
                temp_upd_r <= 1'b1;
            end
            if (cfg_wr_r && wr_byte_r[OS_BIT] && cfg_r[SD_BIT])
                os_pend_r <= 1'b1;
            else if (cv.done && os_run_r)
                os_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            sda_out_r <= 1'b0;
        else
            sda_out_r <= 1'b0;
    end

    assign sda_pin_out = sda_out_r;
    assign sda_pin_oe = sda_oe_r;
    assign resolution_select = cfg_r[RES_LSB +: 2];
    assign fault_queue_depth = cfg_r[FQ_LSB +: 2];
    assign alarm_polarity = cfg_r[POL_BIT];
    assign alarm_mode_select = cfg_r[MODE_BIT];
    assign shutdown_ctrl = cfg_r[SD_BIT];
    assign conv_busy = cv.busy;
    assign temp_update = temp_upd_r;
    assign temp_value = temp_r;
endmodule // thermal_sensor_config_reg
`default_nettype wire

// ### rtl/thermal_cfg_pkg.sv
// Purpose: Shared constants and types for the sensor control register block.
// Assumes: 25 MHz reference clock.
// Notes: The configuration byte holds the upper byte of the 16-bit register.
`default_nettype none
package thermal_cfg_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_US = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    localparam int CONV_9BIT_MS = 25;
    localparam int CONV_9BIT_TICKS = CONV_9BIT_MS * 1000 / TICK_US;
    localparam int CONV_CNT_W = 18;
    localparam logic [7:0] PTR_TEMP = 8'h00;
    localparam logic [7:0] PTR_CFG = 8'h01;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_LOW_BYTE = 8'h00;
    localparam logic [15:0] TEMP_RESET = 16'h0000;
    localparam logic [15:0] UNMAPPED_WORD = 16'h0000;
    localparam logic [3:0] ADDR_PREFIX = 4'h9;
    localparam int OS_BIT = 7;
    localparam int RES_LSB = 5;
    localparam int FQ_LSB = 3;
    localparam int POL_BIT = 2;
    localparam int MODE_BIT = 1;
    localparam int SD_BIT = 0;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [1:0] IDX_ADDR = 2'h0;
    localparam logic [1:0] IDX_PTR = 2'h1;
    localparam logic [1:0] IDX_DATA = 2'h2;
    localparam logic [1:0] IDX_MAX = 2'h3;
    typedef logic [1:0] res_t;
    typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} i2c_state_e;
endpackage
`default_nettype wire

// ### rtl/conv_if.sv
// Purpose: Handshake between the register block and the conversion timer.
// Assumes: Both ends run on ref_clk.
// Notes: start is a one-cycle pulse, done a one-cycle pulse.
`default_nettype none
interface conv_if;
    logic start;
    thermal_cfg_pkg::res_t res;
    logic busy;
    logic done;
    modport ctl (output start, output res, input busy, input done);
    modport eng (input start, input res, output busy, output done);
endinterface
`default_nettype wire

// ### rtl/conv_timer.sv
// Purpose: Times one temperature conversion per start pulse.
// Assumes: start is only raised while busy is low.
// Notes: Conversion length doubles with each resolution step.
`default_nettype none
module conv_timer #(
    parameter int BASE_TICKS = thermal_cfg_pkg::CONV_9BIT_TICKS,
    parameter int CNT_W = thermal_cfg_pkg::CONV_CNT_W
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    conv_if.eng cv
);
    import thermal_cfg_pkg::*;

    logic [7:0] div_r;
    logic tick_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] target_r;
    logic last;

    // Counting one tick past the target means a conversion is never shorter than nominal.
    assign last = tick_r && (cnt_r == target_r);

    // Microsecond tick; free running so the divider needs no restart logic.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_r <= 8'h00;
            tick_r <= 1'b0;
        end else if (div_r == 8'(TICK_CYCLES - 1)) begin
            div_r <= 8'h00;
            tick_r <= 1'b1;
        end else begin
            div_r <= div_r + 8'h01;
            tick_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cv.busy <= 1'b0;
            cv.done <= 1'b0;
            cnt_r <= '0;
            target_r <= '0;
        end else begin
            cv.done <= 1'b0;
            if (cv.start && !cv.busy) begin
                cv.busy <= 1'b1;
                cnt_r <= '0;
                target_r <= CNT_W'(BASE_TICKS) << cv.res;
            end else if (cv.busy && last) begin
                cv.busy <= 1'b0;
                cv.done <= 1'b1;
            end else if (cv.busy && tick_r) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule // conv_timer
`default_nettype wire

// ### verif/thermal_cfg_sva.sv
// Purpose: Port-level checks of the sensor control register block.
// Assumes: Each SCL phase lasts at least 8 ref_clk cycles.
// Notes: Conversion length bounds span all four resolutions.
`default_nettype none
module thermal_cfg_sva #(
    parameter int CONV_BASE_TICKS = thermal_cfg_pkg::CONV_9BIT_TICKS
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic scl_pin,
    input wire logic sda_pin_oe,
    input wire logic [15:0] temp_sample,
    input wire logic [1:0] resolution_select,
    input wire logic [1:0] fault_queue_depth,
    input wire logic alarm_polarity,
    input wire logic alarm_mode_select,
    input wire logic shutdown_ctrl,
    input wire logic conv_busy,
    input wire logic temp_update,
    input wire logic [15:0] temp_value
);
    timeunit 1ns;
    timeprecision 1ns;
    import thermal_cfg_pkg::*;
    localparam int LEN_LO = CONV_BASE_TICKS * TICK_CYCLES;
    localparam int LEN_HI = LEN_LO * 8 + 2 * TICK_CYCLES;
    logic [23:0] busy_cnt_r;
    logic [6:0] cfg_out;
    assign cfg_out = {resolution_select, fault_queue_depth, alarm_polarity, alarm_mode_select,
        shutdown_ctrl};
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            busy_cnt_r <= 24'h000000;
        else if (conv_busy)
            busy_cnt_r <= busy_cnt_r + 24'h000001;
        else
            busy_cnt_r <= 24'h000000;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    reset_val_a: assert property ($rose(reset_n) |-> cfg_out == 7'h00 && !sda_pin_oe)
        else $error("control outputs not cleared by reset");
    temp_load_a: assert property (temp_update |-> temp_value == $past(temp_sample))
        else $error("temperature not loaded from sample");
    upd_pulse_a: assert property (temp_update |=> !temp_update)
        else $error("update pulse longer than one cycle");
    busy_done_a: assert property ($fell(conv_busy) |-> ##[0:3] temp_update)
        else $error("conversion end without update");
    back_to_back_a: assert property (!shutdown_ctrl && temp_update |-> ##[1:4] conv_busy)
        else $error("no new conversion while running");
    conv_len_a: assert property ($fell(conv_busy) |-> busy_cnt_r >= LEN_LO && busy_cnt_r <= LEN_HI)
        else $error("conversion length out of range");
    ack_phase_a: assert property ($changed(sda_pin_oe) |-> !scl_pin)
        else $error("data line changed while clock high");
    cfg_phase_a: assert property ($changed(cfg_out) |-> scl_pin)
        else $error("control changed outside a data bit");
    cover property (shutdown_ctrl && temp_update);
    cover property ($rose(sda_pin_oe));
    cover property (resolution_select == 2'h3 && $fell(conv_busy));
endmodule // thermal_cfg_sva
`default_nettype wire

// ### verif/i2c_master_model.sv
// Purpose: Bus master stand-in that clocks bits on the two-wire bus.
// Assumes: SDA has a pull-up, so a released line reads high.
// Notes: Each SCL phase is at least 8 ref_clk long so the synchronisers keep up.
`default_nettype none
module i2c_master_model (
    input wire logic ref_clk,
    input wire logic sda_dev_oe,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sda_low = 1'b0;
    initial scl = 1'b1;
    assign sda = ~(sda_low | sda_dev_oe);
    task automatic tk(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        tk(4);
        scl = 1'b1;
        tk(8);
        r = sda;
        scl = 1'b0;
        tk(4);
    endtask
    task automatic start();
        sda_low = 1'b0;
        tk(4);
        scl = 1'b1;
        tk(8);
        sda_low = 1'b1;
        tk(8);
        scl = 1'b0;
        tk(4);
    endtask
    task automatic stop();
        sda_low = 1'b1;
        tk(4);
        scl = 1'b1;
        tk(8);
        sda_low = 1'b0;
        tk(8);
    endtask
    task automatic put(input logic [7:0] d, input int n, output logic ack);
        logic r;
        int i;
        ack = 1'b1;
        for (i = 7; i > 7 - n; i--)
            bit_io(d[i], r);
        if (n == 8)
            bit_io(1'b1, ack);
    endtask
    // The master acknowledges to ask for more and releases to end a read.
    task automatic get(input logic mack, output logic [7:0] d);
        logic r;
        int i;
        for (i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(~mack, r);
    endtask
endmodule // i2c_master_model
`default_nettype wire

// ### verif/thermal_sensor_config_reg_test.sv
// Purpose: Self-checking bench for the sensor control register block.
// Assumes: A short conversion base keeps the run brief.
// Notes: All bus traffic goes through the master model tasks.
`default_nettype none
module thermal_sensor_config_reg_test;
    timeunit 1ns;
    timeprecision 1ns;
    import thermal_cfg_pkg::*;
    localparam int BASE = 4;
    localparam logic [2:0] STRAP = 3'h5;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    wire logic scl_pin;
    wire logic sda_pin_in;
    logic sda_pin_out, sda_pin_oe, alarm_polarity, alarm_mode_select, shutdown_ctrl;
    logic conv_busy, temp_update;
    logic [2:0] addr_strap_pins = STRAP;
    logic [15:0] temp_sample = 16'h1940;
    logic [15:0] temp_value;
    logic [1:0] resolution_select, fault_queue_depth;
    int error_cnt = 0;
    int checks = 0;
    thermal_sensor_config_reg #(.CONV_BASE_TICKS(BASE)) thermal_sensor_config_reg_i (.ref_clk,
        .reset_n, .scl_pin, .sda_pin_in, .sda_pin_out, .sda_pin_oe, .addr_strap_pins,
        .temp_sample, .resolution_select, .fault_queue_depth, .alarm_polarity,
        .alarm_mode_select, .shutdown_ctrl, .conv_busy, .temp_update, .temp_value);
    i2c_master_model i2c_master_model_i (.ref_clk, .sda_dev_oe(sda_pin_oe), .scl(scl_pin),
        .sda(sda_pin_in));
    always #20 ref_clk = ~ref_clk;
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Bounded waits: a hang counts as a mismatch and ends the run.
    task automatic wait_busy(input logic v, output int n);
        n = 0;
        while (conv_busy !== v) begin
            tk(1);
            n++;
            if (n > 2000) begin
                chk("conv_busy wait", {15'h0, v}, {15'h0, conv_busy});
                stop_test();
            end
        end
    endtask
    task automatic wait_upd();
        int n;
        n = 0;
        while (temp_update !== 1'b1) begin
            tk(1);
            n++;
            if (n > 3000) begin
                chk("temp_update wait", 16'h0001, {15'h0, temp_update});
                stop_test();
            end
        end
    endtask
    task automatic quiet(input string nm);
        logic s;
        int i;
        s = 1'b0;
        for (i = 0; i < 300; i++) begin
            tk(1);
            s = s | conv_busy;
        end
        chk(nm, 16'h0000, {15'h0, s});
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d0, input int n0,
        input logic [7:0] d1, input int n1);
        logic a, any;
        i2c_master_model_i.start();
        i2c_master_model_i.put({ADDR_PREFIX, STRAP, 1'b0}, 8, any);
        i2c_master_model_i.put(p, 8, a);
        any = any | a;
        if (n0 > 0)
            i2c_master_model_i.put(d0, n0, a);
        if (n0 == 8)
            any = any | a;
        if (n1 > 0)
            i2c_master_model_i.put(d1, n1, a);
        i2c_master_model_i.stop();
        chk("write acks", 16'h0000, {15'h0, any});
    endtask
    task automatic rd(input logic [15:0] e, input string nm);
        logic a;
        logic [7:0] h, l;
        i2c_master_model_i.start();
        i2c_master_model_i.put({ADDR_PREFIX, STRAP, 1'b1}, 8, a);
        i2c_master_model_i.get(1'b1, h);
        i2c_master_model_i.get(1'b0, l);
        i2c_master_model_i.stop();
        chk(nm, e, {h, l});
    endtask
    task automatic cfg_chk(input logic [7:0] d);
        chk("control outputs", {9'h000, d[6:0]}, {9'h000, resolution_select,
            fault_queue_depth, alarm_polarity, alarm_mode_select, shutdown_ctrl});
    endtask
    initial begin
        int n, r, lo;
        logic a;
        logic [7:0] h, l;
        tk(5);
        reset_n = 1'b1;
        tk(3);
        cfg_chk(8'h00);
        chk("temp reset", 16'h0000, temp_value);
        chk("sda out", 16'h0000, {15'h0, sda_pin_out});
        wait_upd();
        rd(16'h1940, "temp read");
        $display("test defaults finished");
        wr(8'h01, 8'h7E, 8, 8'h02, 8);
        cfg_chk(8'h7E);
        rd(16'h7E00, "cfg read");
        wr(8'h01, 8'hFE, 8, 8'h00, 0);
        rd(16'h7E00, "shot while running");
        wr(8'h01, 8'h00, 5, 8'h00, 0);
        rd(16'h7E00, "partial byte");
        $display("test writes finished");
        for (r = 0; r < 4; r++) begin
            wr(8'h01, {1'b0, r[1:0], 5'h00}, 8, 8'h00, 0);
            wait_busy(1'b0, n);
            wait_busy(1'b1, n);
            wait_busy(1'b0, n);
            lo = (BASE * TICK_CYCLES) << r;
            chk("conv length ok", 16'h0001, {15'h0, n >= lo && n <= lo + 30});
        end
        $display("test conversion time finished");
        temp_sample = 16'h0A20;
        wait_busy(1'b1, n);
        wr(8'h01, 8'h01, 8, 8'h00, 0);
        wait_upd();
        chk("temp before sleep", 16'h0A20, temp_value);
        quiet("busy in shutdown");
        temp_sample = 16'hF5E0;
        wr(8'h01, 8'h81, 8, 8'h00, 0);
        wait_upd();
        chk("temp single shot", 16'hF5E0, temp_value);
        quiet("busy after shot");
        rd(16'h0100, "shot cleared");
        temp_sample = 16'h3280;
        wr(8'h01, 8'h00, 8, 8'h00, 0);
        wait_upd();
        chk("temp resumed", 16'h3280, temp_value);
        wait_upd();
        $display("test shutdown finished");
        i2c_master_model_i.start();
        i2c_master_model_i.put({ADDR_PREFIX, ~STRAP, 1'b0}, 8, a);
        i2c_master_model_i.stop();
        chk("foreign address", 16'h0001, {15'h0, a});
        wr(8'h02, 8'h00, 0, 8'h00, 0);
        rd(16'h0000, "unmapped pointer");
        wr(8'h00, 8'h00, 0, 8'h00, 0);
        rd(16'h3280, "temp pointer");
        i2c_master_model_i.start();
        i2c_master_model_i.put({ADDR_PREFIX, STRAP, 1'b1}, 8, a);
        chk("read address ack", 16'h0000, {15'h0, a});
        i2c_master_model_i.get(1'b1, h);
        i2c_master_model_i.get(1'b1, l);
        chk("read first pass", 16'h3280, {h, l});
        i2c_master_model_i.get(1'b1, h);
        i2c_master_model_i.get(1'b0, l);
        i2c_master_model_i.stop();
        chk("read repeated", 16'h3280, {h, l});
        $display("test pointer finished");
        stop_test();
    end
endmodule // thermal_sensor_config_reg_test
bind thermal_sensor_config_reg thermal_cfg_sva #(.CONV_BASE_TICKS(CONV_BASE_TICKS))
    thermal_cfg_sva_i (.ref_clk, .reset_n, .scl_pin, .sda_pin_oe, .temp_sample,
    .resolution_select, .fault_queue_depth, .alarm_polarity, .alarm_mode_select,
    .shutdown_ctrl, .conv_busy, .temp_update, .temp_value);
`default_nettype wire
